// ==== core/rbv_consts.vh ====
// constants for the reset cause and bus error vector generator
// assumes a 16-bit classic wishbone slave with word-aligned registers
`ifndef RBV_CONSTS_VH
`define RBV_CONSTS_VH

`define RBV_ADR_RST_VEC     4'h0
`define RBV_ADR_BERR_VEC    4'h4
`define RBV_ADR_INT_STAT    4'h8
`define RBV_ADR_INT_MASK    4'hc

`define RBV_NUM_CAUSES      14
`define RBV_INT_BITS        2
`define RBV_INT_RST_BIT     0
`define RBV_INT_BERR_BIT    1
`define RBV_MASK_RESET      2'h0

`define RBV_BERR_TIMEOUT    8

`define RBV_CODE_NONE       8'h00
`define RBV_CODE_BROWNOUT   8'h02
`define RBV_CODE_RST_PIN    8'h04
`define RBV_CODE_SW_BOR     8'h06
`define RBV_CODE_DEEP_WAKE  8'h08
`define RBV_CODE_SECURITY   8'h0a
`define RBV_CODE_LSS        8'h0c
`define RBV_CODE_LS_OVP     8'h10
`define RBV_CODE_HS_OVP     8'h12
`define RBV_CODE_SW_POR     8'h14
`define RBV_CODE_WD_TMO     8'h16
`define RBV_CODE_WD_PW      8'h18
`define RBV_CODE_PERIPHERAL_AREA_FETCH       8'h1e
`define RBV_CODE_PM_PW      8'h20
`define RBV_CODE_BERR_USB   8'h02

`endif

// ==== core/rbv_wait_watch.v ====
// counts consecutive usb wait-state cycles and pulses on timeout
// assumes usb_wait_i is on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "rbv_consts.vh"
module rbv_wait_watch #(
    parameter LIMIT = `RBV_BERR_TIMEOUT
) (
    // system
    input  wire       clk_i,
    input  wire       rst_i,
    // wait state in, timeout out
    input  wire       wait_i,
    output reg        tmo_o
);
    reg  [4:0] cnt_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 5'h00;
            tmo_o <= 1'b0;
        end
        else
        begin
            tmo_o <= 1'b0;
            if (!wait_i)
                cnt_r <= 5'h00;
            else if (cnt_r == LIMIT - 1)
            begin
                // one pulse per stalled access
                tmo_o <= 1'b1;
                cnt_r <= cnt_r + 5'h01;
            end
            else if (cnt_r < LIMIT)
                cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule
`default_nettype wire

// ==== core/rbv_top.v ====
// reset cause and bus error vector generator with wishbone slave
// assumes reset-cause flags are level strobes from the reset hierarchy, on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "rbv_consts.vh"
module rbv_top #(
    parameter BERR_TIMEOUT = `RBV_BERR_TIMEOUT
) (
    // system
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [1:0]  sel_i,
    input  wire [15:0] dat_i,
    output reg  [15:0] dat_o,
    output reg         ack_o,
    // reset cause events, bit order brownout..pm password
    input  wire [13:0] cause_i,
    // usb wait state
    input  wire        usb_wait_i,
    // interrupt
    output reg         irq_o
);
    reg  [13:0] pend_r;
    reg         berr_r;
    reg  [1:0]  stat_r;
    reg  [1:0]  mask_r;
    wire        usb_tmo;
    wire        acc;
    wire        wr;
    reg  [7:0]  rst_code;
    reg  [7:0]  berr_code;
    reg  [1:0]  stat_nxt;
    integer     i;

    // code for each cause bit, lowest index = highest priority
    function [7:0] cause_code;
        input [3:0] idx;
        begin
            case (idx)
                4'd0:    cause_code = `RBV_CODE_BROWNOUT;
                4'd1:    cause_code = `RBV_CODE_RST_PIN;
                4'd2:    cause_code = `RBV_CODE_SW_BOR;
                4'd3:    cause_code = `RBV_CODE_DEEP_WAKE;
                4'd4:    cause_code = `RBV_CODE_SECURITY;
                4'd5:    cause_code = `RBV_CODE_LSS;
                4'd6:    cause_code = `RBV_CODE_LS_OVP;
                4'd7:    cause_code = `RBV_CODE_HS_OVP;
                4'd8:    cause_code = `RBV_CODE_SW_POR;
                4'd9:    cause_code = `RBV_CODE_WD_TMO;
                4'd10:   cause_code = `RBV_CODE_WD_PW;
                4'd11:   cause_code = `RBV_CODE_PERIPHERAL_AREA_FETCH;
                4'd12:   cause_code = `RBV_CODE_PM_PW;
                default: cause_code = `RBV_CODE_NONE;
            endcase
        end
    endfunction

    rbv_wait_watch #(
        .LIMIT (BERR_TIMEOUT)
    ) u_watch (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .wait_i (usb_wait_i),
        .tmo_o  (usb_tmo)
    );

    assign acc = cyc_i & stb_i & ~ack_o;
    assign wr  = acc & we_i;

    // priority encode, scanning from lowest priority so the highest wins
    always @*
    begin
        rst_code = `RBV_CODE_NONE;
        for (i = `RBV_NUM_CAUSES - 1; i >= 0; i = i - 1)
            if (pend_r[i])
                rst_code = cause_code(i[3:0]);
        rst_code[0] = 1'b0;
    end

    always @*
    begin
        // only the usb source exists; reserved codes are unreachable
        berr_code = berr_r ? `RBV_CODE_BERR_USB : `RBV_CODE_NONE;
    end

    // pending reset-cause flags; a cause seen in a clear cycle survives
    always @(posedge clk_i)
    begin
        if (rst_i)
            pend_r <= 14'h0000;
        else if (wr && adr_i == `RBV_ADR_RST_VEC)
            pend_r <= cause_i;
        else
            pend_r <= pend_r | cause_i;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            berr_r <= 1'b0;
        else if (usb_tmo)
            berr_r <= 1'b1;
        else if (wr && adr_i == `RBV_ADR_BERR_VEC)
            berr_r <= 1'b0;
    end

    // sticky status: set on new pending cause or bus error, write one clears
    always @*
    begin
        stat_nxt = stat_r;
        if (wr && adr_i == `RBV_ADR_INT_STAT)
            stat_nxt = stat_r & ~dat_i[1:0];
        if (|(cause_i & ~pend_r))
            stat_nxt[`RBV_INT_RST_BIT] = 1'b1;
        if (usb_tmo)
            stat_nxt[`RBV_INT_BERR_BIT] = 1'b1;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_r <= 2'h0;
            mask_r <= `RBV_MASK_RESET;
            irq_o  <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            if (wr && adr_i == `RBV_ADR_INT_MASK && sel_i[0])
                mask_r <= dat_i[1:0];
            irq_o <= |(stat_nxt & mask_r);
        end
    end

    // one-wait-state bus answer
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 16'h0000;
        end
        else
        begin
            ack_o <= acc;
            dat_o <= 16'h0000;
            if (acc && !we_i)
            begin
                case (adr_i)
                    `RBV_ADR_RST_VEC:  dat_o <= {8'h00, rst_code};
                    `RBV_ADR_BERR_VEC: dat_o <= {8'h00, berr_code};
                    `RBV_ADR_INT_STAT: dat_o <= {14'h0000, stat_r};
                    `RBV_ADR_INT_MASK: dat_o <= {14'h0000, mask_r};
                    default:           dat_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/rbv_usb_model.sv ====
// usb side model: holds the wait state for len_i edges after go_i
// assumes go_i is a one-cycle request on clk_i
`timescale 1ns/1ps
`default_nettype none
module rbv_usb_model (
    // request and wait state
    input  wire       clk_i,
    input  wire       go_i,
    input  wire [4:0] len_i,
    output reg        wait_o = 1'b0
);
    reg [4:0] left_r = 5'h00;
    always @(posedge clk_i)
    begin
        left_r <= go_i ? len_i : left_r - {4'h0, left_r != 5'h00};
        wait_o <= go_i || left_r > 5'h01;
    end
endmodule
`default_nettype wire

// ==== verification/rbv_top_properties.sv ====
// port assertions for the vector generator
// assumes it is bound into rbv_top
`timescale 1ns/1ps
`default_nettype none
module rbv_props #(
    parameter BERR_TIMEOUT = 8
) (
    // system
    input wire        clk_i,
    input wire        rst_i,
    // bus, wait state, interrupt
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [3:0]  adr_i,
    input wire [15:0] dat_o,
    input wire        ack_o,
    input wire        usb_wait_i,
    input wire        irq_o
);
    reg [4:0] run_r = 5'h00;
    reg       seen_r = 1'b0;
    wire      rd = ack_o && !we_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // seen_r: a full-length wait run has happened since reset
    always @(posedge clk_i)
    begin
        run_r  <= (rst_i || !usb_wait_i) ? 5'h00 : run_r + {4'h0, run_r != 5'h1f};
        seen_r <= !rst_i && (seen_r || run_r >= BERR_TIMEOUT);
    end
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_data_idle: assert property (!ack_o |-> dat_o == 16'h0000) else $error("stray data");
    a_code_even: assert property (rd && !adr_i[3] |-> !dat_o[0]) else $error("odd code");
    a_rst_range: assert property (rd && adr_i == 4'h0 |-> dat_o[15:6] == 10'h000 && dat_o != 16'h001c)
        else $error("bad cause code");
    a_berr_codes: assert property (rd && adr_i == 4'h4 |-> dat_o[15:2] == 14'h0000) else $error("bad code");
    a_berr_cause: assert property (rd && adr_i == 4'h4 && dat_o[1] |-> seen_r) else $error("early error");
    a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o) else $error("busy in reset");
endmodule
bind rbv_top rbv_props #(.BERR_TIMEOUT(BERR_TIMEOUT)) i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .usb_wait_i(usb_wait_i), .irq_o(irq_o));
`default_nettype wire

// ==== verification/rbv_top_tb.sv ====
// bench: wishbone tasks driving reset cause and usb wait scenarios
// assumes rbv_top, rbv_usb_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module rbv_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, we_i = 1'b0, go = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [4:0]  len = 5'h00;
    logic [13:0] cause_i = 14'h0000;
    logic [15:0] dat_i = 16'h0000;
    wire  [15:0] dat_o;
    wire         ack_o, irq_o, usb_wait;
    int          failures = 0, n_compared = 0;
    logic [7:0]  codes [13] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1e, 8'h20};
    always #50 clk_i = ~clk_i;
    rbv_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(cyc_i), .we_i(we_i), .adr_i(adr_i), .sel_i(2'h3),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cause_i(cause_i), .usb_wait_i(usb_wait), .irq_o(irq_o));
    rbv_usb_model i_usb (.clk_i(clk_i), .go_i(go), .len_i(len), .wait_o(usb_wait));
    task close_out;
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        failures += (seen !== exp);
        if (seen !== exp)
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
    endtask
    // for reads d is the expected data; the tail leaves irq settled
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n = 0;
        {cyc_i, we_i, adr_i, dat_i} <= {1'b1, w, a, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (!w)
            check(dat_o, d);
        cyc_i <= 1'b0;
        failures += (n == 20);
        if (n == 20)
            close_out();
        repeat (2) @(posedge clk_i);
    endtask
    task ev(input logic [13:0] c, input logic [4:0] n);
        {cause_i, go, len} <= {c, n != 5'h00, n};
        @(posedge clk_i);
        {cause_i, go} <= 15'h0000;
        repeat (12) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b0, 4'h4, 16'h0000);
        for (int i = 0; i < 13; i++)
        begin
            ev(14'h0001 << i, 5'h00);
            acc(1'b0, 4'h0, {8'h00, codes[i]});
            acc(1'b1, 4'h0, 16'h5a5a);
            acc(1'b0, 4'h0, 16'h0000);
        end
        ev(14'h1022, 5'h00);
        acc(1'b0, 4'h0, 16'h0004);
        check({15'h0000, irq_o}, 16'h0000);
        acc(1'b1, 4'hc, 16'h0003);
        check({15'h0000, irq_o}, 16'h0001);
        acc(1'b1, 4'h8, 16'h0003);
        check({15'h0000, irq_o}, 16'h0000);
        ev(14'h0000, 5'h07);
        acc(1'b0, 4'h4, 16'h0000);
        ev(14'h0000, 5'h08);
        check({15'h0000, irq_o}, 16'h0001);
        acc(1'b0, 4'h4, 16'h0002);
        acc(1'b1, 4'h4, 16'h0000);
        acc(1'b0, 4'h4, 16'h0000);
        acc(1'b0, 4'h2, 16'h0000);
        acc(1'b0, 4'h8, 16'h0002);
        acc(1'b0, 4'hc, 16'h0003);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({15'h0000, irq_o}, 16'h0000);
        acc(1'b0, 4'hc, 16'h0000);
        acc(1'b0, 4'h8, 16'h0000);
        acc(1'b0, 4'h0, 16'h0000);
        close_out();
    end
endmodule
`default_nettype wire
